// ===== core/burst4_pkg.sv
package burst4_pkg;
    // Clock figures; the link half period is derived from them
    localparam int CLK_PERIOD_NS = 4;
    localparam int K_PERIOD_NS = 160;
    localparam int K_HALF_CYCLES = K_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int DLL_LOCK_KCYCLES = 2048;
    localparam int LANE_BITS = 9;
    localparam int BURST_LEN = 4;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // Host sequence steps, one per half period of the link clock
    localparam logic [2:0] STEP_CMD = 3'h0;
    localparam logic [2:0] STEP_DESEL = 3'h1;
    localparam logic [2:0] STEP_WR_FIRST = 3'h2;
    localparam logic [2:0] STEP_RD_FIRST = 3'h4;
    localparam logic [2:0] STEP_WR_END = 3'h6;
    localparam logic [2:0] STEP_RD_END = 3'h7;

    typedef enum logic [1:0] {
        H_LOCK = 2'b00,
        H_IDLE = 2'b01,
        H_RUN = 2'b10
    } host_state_type;
endpackage

// ===== core/burst4_link_if.sv
`timescale 1ns/1ps
interface burst4_link_if #(
    parameter int DW = 18,
    parameter int AW = 8
);
    localparam int LANES = DW / 9;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic dll_on;
    logic port_select_n;
    logic rw;
    logic [AW-1:0] addr;
    logic [LANES-1:0] lane_wr_n;
    logic [DW-1:0] host_dq;
    logic host_dq_oe;
    logic [DW-1:0] dev_dq;
    logic dev_dq_oe;
    logic [DW-1:0] dq;

    // Shared data wire; the bench checks the enables for contention
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

    modport dev (
        input k, k_n, c, c_n, dll_on, port_select_n, rw, addr, lane_wr_n, dq,
        output dev_dq, dev_dq_oe
    );
    modport host (
        output k, k_n, c, c_n, dll_on, port_select_n, rw, addr, lane_wr_n,
        output host_dq, host_dq_oe,
        input dq
    );
endinterface

// ===== core/burst4_sram_dev.sv
`timescale 1ns/1ps
// Function
// - Stopped clock holds bursts and output beats
// - Deselected edge is no operation, bus released
// - Read returns four words from C#(t+1)
// - Controller presents write words on four edges
// - Two lane enables mask 18-bit write beats
// - Four lane enables mask 36-bit write beats
// - Lane enables sampled at every data edge
// - Lane enables ignored outside write bursts
// - Each enable governs one nine-bit lane
// - Output clocks high at start: use input clocks
// - Controller waits 2048 cycles after DLL enable
module burst4_sram_dev
    import burst4_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 8
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Asynchronous reset, active high
    burst4_link_if.dev link, // Memory pins
    output logic single_clk_out, // Output beats follow the input clocks
    output logic busy_out // A burst is pending or running
);
    localparam int LANES = DW / LANE_BITS;
    localparam int SW = 7 + AW + LANES + DW;

    if ((DW != 18 && DW != 36) || AW < 2 || AW > 20) begin : g_bad_params
        $error("burst4_sram_dev: width must be 18 or 36, address 2 to 20 bits");
    end

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Every pin passes two flip-flops before any logic reads it
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [3:0] edge_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            edge_q <= '0;
        end else begin
            s1_q <= {link.k, link.k_n, link.c, link.c_n, link.dll_on, link.port_select_n,
                     link.rw, link.addr, link.lane_wr_n, link.dq};
            s2_q <= s1_q;
            edge_q <= s2_q[SW-1 -: 4];
        end
    end

    logic k_s;
    logic kn_s;
    logic c_s;
    logic cn_s;
    logic dll_s;
    logic psel_n_s;
    logic rw_s;
    logic [AW-1:0] addr_s;
    logic [LANES-1:0] lane_s;
    logic [DW-1:0] dq_s;
    assign {k_s, kn_s, c_s, cn_s, dll_s, psel_n_s, rw_s, addr_s, lane_s, dq_s} = s2_q;

    logic k_rise;
    logic kn_rise;
    logic oc_rise;
    logic ocn_rise;
    logic single_q;
    logic single_d;
    assign k_rise = k_s & ~edge_q[3];
    assign kn_rise = kn_s & ~edge_q[2];
    // Output beats ride the chosen clock pair; with no edges everything holds
    assign oc_rise = single_q ? k_rise : (c_s & ~edge_q[1]);
    assign ocn_rise = single_q ? kn_rise : (cn_s & ~edge_q[0]);

    logic [1:0] strap_q, strap_d;
    logic skip_q, skip_d;
    logic wr_pend_q, wr_pend_d;
    logic [AW-1:0] wr_next_q, wr_next_d;
    logic wr_busy_q, wr_busy_d;
    logic [1:0] wr_beat_q, wr_beat_d;
    logic [AW-1:0] wr_base_q, wr_base_d;
    logic rd_pend_q, rd_pend_d;
    logic rd_armed_q, rd_armed_d;
    logic [AW-1:0] rd_next_q, rd_next_d;
    logic rd_busy_q, rd_busy_d;
    logic [1:0] rd_beat_q, rd_beat_d;
    logic [AW-1:0] rd_base_q, rd_base_d;
    logic [DW-1:0] dq_q, dq_d;
    logic oe_q, oe_d;
    logic busy_q, busy_d;

    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [DW-1:0] mem_wd;
    logic [DW-1:0] mem_old;
    logic [AW-1:0] mem_ra;
    logic [DW-1:0] mem_rd;

    always_comb begin
        strap_d = strap_q;
        single_d = single_q;
        skip_d = skip_q;
        wr_pend_d = wr_pend_q;
        wr_next_d = wr_next_q;
        wr_busy_d = wr_busy_q;
        wr_beat_d = wr_beat_q;
        wr_base_d = wr_base_q;
        rd_pend_d = rd_pend_q;
        rd_armed_d = rd_armed_q;
        rd_next_d = rd_next_q;
        rd_busy_d = rd_busy_q;
        rd_beat_d = rd_beat_q;
        rd_base_d = rd_base_q;
        dq_d = dq_q;
        oe_d = oe_q;
        mem_we = 1'b0;
        mem_wa = wr_base_q;
        mem_wd = '0;
        mem_old = '0;
        mem_ra = rd_base_q;
        mem_rd = '0;

        // Strap caught once the synchroniser has filled after reset
        if (strap_q != STRAP_DONE) begin
            strap_d = strap_q + 2'h1;
            single_d = c_s & cn_s;
        end

        // Write beats; a pending write opens on the next true edge
        if (k_rise && wr_pend_q) begin
            mem_we = 1'b1;
            mem_wa = wr_next_q;
            wr_base_d = wr_next_q;
            wr_busy_d = 1'b1;
            wr_beat_d = 2'h1;
            wr_pend_d = 1'b0;
        end else if (wr_busy_q && (k_rise || kn_rise)) begin
            mem_we = 1'b1;
            mem_wa = {wr_base_q[AW-1:2], wr_base_q[1:0] + wr_beat_q};
            wr_beat_d = wr_beat_q + 2'h1;
            if (wr_beat_q == LAST_BEAT) begin
                wr_busy_d = 1'b0;
            end
        end
        // Lane enables only reach the array through a write beat
        if (mem_we) begin
            mem_old = mem[mem_wa];
            for (int i = 0; i < LANES; i++) begin
                // Low enable takes the new nine bits, high keeps the stored ones
                mem_wd[i*LANE_BITS +: LANE_BITS] = lane_s[i] ?
                    mem_old[i*LANE_BITS +: LANE_BITS] :
                    dq_s[i*LANE_BITS +: LANE_BITS];
            end
        end

        // A read becomes armed at the true edge after its command
        if (k_rise && rd_pend_q) begin
            rd_armed_d = 1'b1;
            rd_pend_d = 1'b0;
        end

        if (rd_armed_q && ocn_rise) begin
            mem_ra = rd_next_q;
        end else begin
            mem_ra = {rd_base_q[AW-1:2], rd_base_q[1:0] + rd_beat_q};
        end
        // Same-cycle write forwarded so a read never sees stale data
        mem_rd = (mem_we && mem_wa == mem_ra) ? mem_wd : mem[mem_ra];

        if (oc_rise || ocn_rise) begin
            if (rd_armed_q && ocn_rise) begin
                // A0 on the complement edge of cycle t+1
                rd_base_d = rd_next_q;
                rd_beat_d = 2'h1;
                rd_busy_d = 1'b1;
                rd_armed_d = 1'b0;
                dq_d = mem_rd;
                oe_d = 1'b1;
            end else if (rd_busy_q) begin
                dq_d = mem_rd;
                rd_beat_d = rd_beat_q + 2'h1;
                if (rd_beat_q == LAST_BEAT) begin
                    rd_busy_d = 1'b0;
                end
            end else begin
                oe_d = 1'b0;
            end
        end

        // Commands; the edge after an accepted one is the burst's second half
        if (k_rise) begin
            skip_d = 1'b0;
            if (!skip_q && dll_s && !psel_n_s) begin
                skip_d = 1'b1;
                if (rw_s) begin
                    rd_pend_d = 1'b1;
                    rd_next_d = addr_s;
                end else begin
                    wr_pend_d = 1'b1;
                    wr_next_d = addr_s;
                end
            end
        end

        busy_d = wr_pend_d | wr_busy_d | rd_pend_d | rd_armed_d | rd_busy_d | oe_d;
    end

    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            strap_q <= 2'h0;
            single_q <= 1'b0;
            skip_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_next_q <= '0;
            wr_busy_q <= 1'b0;
            wr_beat_q <= 2'h0;
            wr_base_q <= '0;
            rd_pend_q <= 1'b0;
            rd_armed_q <= 1'b0;
            rd_next_q <= '0;
            rd_busy_q <= 1'b0;
            rd_beat_q <= 2'h0;
            rd_base_q <= '0;
            dq_q <= '0;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            strap_q <= strap_d;
            single_q <= single_d;
            skip_q <= skip_d;
            wr_pend_q <= wr_pend_d;
            wr_next_q <= wr_next_d;
            wr_busy_q <= wr_busy_d;
            wr_beat_q <= wr_beat_d;
            wr_base_q <= wr_base_d;
            rd_pend_q <= rd_pend_d;
            rd_armed_q <= rd_armed_d;
            rd_next_q <= rd_next_d;
            rd_busy_q <= rd_busy_d;
            rd_beat_q <= rd_beat_d;
            rd_base_q <= rd_base_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            busy_q <= busy_d;
        end
    end

    assign link.dev_dq = dq_q;
    assign link.dev_dq_oe = oe_q;
    assign single_clk_out = single_q;
    assign busy_out = busy_q;
endmodule

// ===== core/burst4_sram_host.sv
`timescale 1ns/1ps
module burst4_sram_host
    import burst4_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 8,
    parameter int HALF = K_HALF_CYCLES,
    parameter int LOCK_KCYCLES = DLL_LOCK_KCYCLES,
    parameter bit SINGLE_CLK = 1'b0
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Asynchronous reset, active high
    burst4_link_if.host link, // Memory pins
    input wire logic req_valid_in, // Request offered
    input wire logic req_write_in, // 1 write, 0 read
    input wire logic [AW-1:0] req_addr_in, // Burst start address
    input wire logic [BURST_LEN*DW-1:0] wr_data_in, // Beat 0 in low bits
    input wire logic [BURST_LEN*DW/LANE_BITS-1:0] wr_mask_n_in, // Lane enables per beat
    output logic req_ready_out, // Request taken when high with valid
    output logic [BURST_LEN*DW-1:0] rd_data_out, // Read burst, beat 0 low
    output logic rd_valid_out // One-cycle pulse, read data ready
);
    localparam int LANES = DW / LANE_BITS;
    localparam int QUARTER = HALF / 2;

    if ((DW != 18 && DW != 36) || HALF < 16 || HALF > 127 || LOCK_KCYCLES < 1
        || LOCK_KCYCLES > 65535) begin : g_bad_params
        $error("burst4_sram_host: unsupported width, half period or lock count");
    end

    // Read data is a pin; it passes two flip-flops
    logic [DW-1:0] dq_s1_q;
    logic [DW-1:0] dq_s2_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= link.dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    host_state_type state_q, state_d;
    logic [7:0] phase_q, phase_d;
    logic [15:0] lock_q, lock_d;
    logic [2:0] step_q, step_d;
    logic k_q, k_d, c_q, c_d, cn_q, cn_d;
    logic kn_q;
    logic dll_q, psel_n_q, psel_n_d, rw_q, rw_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [LANES-1:0] lane_q, lane_d;
    logic [DW-1:0] dq_q, dq_d;
    logic oe_q, oe_d, write_q, write_d, ready_q, ready_d, valid_q, valid_d;
    logic [BURST_LEN*DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [BURST_LEN*LANES-1:0] wmask_q, wmask_d;
    logic tick;
    logic [1:0] wbeat;

    always_comb begin
        state_d = state_q;
        lock_d = lock_q;
        step_d = step_q;
        psel_n_d = psel_n_q;
        rw_d = rw_q;
        addr_d = addr_q;
        lane_d = lane_q;
        dq_d = dq_q;
        oe_d = oe_q;
        write_d = write_q;
        ready_d = ready_q;
        valid_d = 1'b0;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        wmask_d = wmask_q;
        wbeat = step_q[1:0] - 2'h2;
        // Link clock made here by division; changes sit a quarter from edges
        phase_d = (phase_q == 8'(2 * HALF - 1)) ? 8'h00 : phase_q + 8'h01;
        k_d = phase_d < 8'(HALF);
        c_d = SINGLE_CLK ? 1'b1 : k_d;
        cn_d = SINGLE_CLK ? 1'b1 : !k_d;
        tick = (phase_q == 8'(HALF + QUARTER)) ||
               (phase_q == 8'(QUARTER) && step_q != STEP_CMD);
        case (state_q)
            H_LOCK: begin
                if (lock_q == 16'(LOCK_KCYCLES)) begin
                    state_d = H_IDLE;
                    ready_d = 1'b1;
                end else if (phase_q == 8'h00) begin
                    lock_d = lock_q + 16'h0001;
                end
            end
            H_IDLE: begin
                if (req_valid_in && ready_q) begin
                    ready_d = 1'b0;
                    state_d = H_RUN;
                    step_d = STEP_CMD;
                    write_d = req_write_in;
                    addr_d = req_addr_in;
                    wdata_d = wr_data_in;
                    wmask_d = wr_mask_n_in;
                end
            end
            H_RUN: begin
                if (tick) begin
                    step_d = step_q + 3'h1;
                    if (step_q == STEP_CMD) begin
                        psel_n_d = 1'b0;
                        rw_d = !write_q;
                    end else if (step_q == STEP_DESEL) begin
                        psel_n_d = 1'b1;
                    end else if (write_q && step_q == STEP_WR_END) begin
                        oe_d = 1'b0;
                        lane_d = '1;
                        state_d = H_IDLE;
                        ready_d = 1'b1;
                        step_d = STEP_CMD;
                    end else if (write_q && step_q >= STEP_WR_FIRST) begin
                        // Each beat carries its own lane mask
                        oe_d = 1'b1;
                        dq_d = wdata_q[wbeat*DW +: DW];
                        lane_d = wmask_q[wbeat*LANES +: LANES];
                    end else if (!write_q && step_q >= STEP_RD_FIRST) begin
                        rdata_d[step_q[1:0]*DW +: DW] = dq_s2_q;
                        if (step_q == STEP_RD_END) begin
                            valid_d = 1'b1;
                            state_d = H_IDLE;
                            ready_d = 1'b1;
                            step_d = STEP_CMD;
                        end
                    end
                end
            end
            default: begin
                state_d = H_LOCK;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= H_LOCK;
            phase_q <= 8'h00;
            lock_q <= 16'h0000;
            step_q <= STEP_CMD;
            k_q <= 1'b0;
            kn_q <= 1'b1;
            // Strap level shown from reset so the device catches it at once
            c_q <= SINGLE_CLK;
            cn_q <= SINGLE_CLK;
            dll_q <= 1'b0;
            psel_n_q <= 1'b1;
            rw_q <= 1'b0;
            addr_q <= '0;
            lane_q <= '1;
            dq_q <= '0;
            oe_q <= 1'b0;
            write_q <= 1'b0;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            wdata_q <= '0;
            rdata_q <= '0;
            wmask_q <= '1;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            lock_q <= lock_d;
            step_q <= step_d;
            k_q <= k_d;
            kn_q <= !k_d;
            c_q <= c_d;
            cn_q <= cn_d;
            dll_q <= 1'b1;
            psel_n_q <= psel_n_d;
            rw_q <= rw_d;
            addr_q <= addr_d;
            lane_q <= lane_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            write_q <= write_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wmask_q <= wmask_d;
        end
    end

    assign link.k = k_q;
    assign link.k_n = kn_q;
    assign link.c = c_q;
    assign link.c_n = cn_q;
    assign link.dll_on = dll_q;
    assign link.port_select_n = psel_n_q;
    assign link.rw = rw_q;
    assign link.addr = addr_q;
    assign link.lane_wr_n = lane_q;
    assign link.host_dq = dq_q;
    assign link.host_dq_oe = oe_q;
    assign req_ready_out = ready_q;
    assign rd_data_out = rdata_q;
    assign rd_valid_out = valid_q;
endmodule

// ===== bench/burst4_link_sva.sv
`timescale 1ns/1ps
module burst4_link_sva #(
    parameter int DW = 18,
    parameter int AW = 8,
    parameter int HALF = 20,
    parameter int LOCK = 2048
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Asynchronous reset, active high
    input wire logic k, // True link clock
    input wire logic k_n, // Complement link clock
    input wire logic c, // True output clock
    input wire logic c_n, // Complement output clock
    input wire logic dll_on, // Lock loop enable
    input wire logic port_select_n, // Command select, active low
    input wire logic rw, // Direction
    input wire logic [AW-1:0] addr, // Burst start address
    input wire logic [DW/9-1:0] lane_wr_n, // Lane write enables
    input wire logic [DW-1:0] host_dq, // Write data
    input wire logic host_dq_oe, // Host drives the bus
    input wire logic [DW-1:0] dev_dq, // Read data
    input wire logic dev_dq_oe // Device drives the bus
);
    logic k_q, k_d;
    logic [7:0] rd_cnt_q, rd_cnt_d, wr_cnt_q, wr_cnt_d;
    logic [15:0] lock_cnt_q, lock_cnt_d;

    always_comb begin
        k_d = k;
        rd_cnt_d = dev_dq_oe ? rd_cnt_q + 8'h01 : 8'h00;
        wr_cnt_d = host_dq_oe ? wr_cnt_q + 8'h01 : 8'h00;
        lock_cnt_d = lock_cnt_q;
        // Saturate so a long run never wraps back under the lock count
        if (!dll_on) begin
            lock_cnt_d = 16'h0000;
        end else if (k && !k_q && lock_cnt_q != 16'hFFFF) begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            k_q <= 1'b0;
            rd_cnt_q <= 8'h00;
            wr_cnt_q <= 8'h00;
            lock_cnt_q <= 16'h0000;
        end else begin
            k_q <= k_d;
            rd_cnt_q <= rd_cnt_d;
            wr_cnt_q <= wr_cnt_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Command pins held across the sampling link edge
    sequence s_cmd_held;
        (!port_select_n && $stable(addr) && $stable(rw)) [*8];
    endsequence
    // Output clock edge seen through the two-flop synchroniser
    sequence s_beat_launch;
        ($past(c_n, 2) && !$past(c_n, 3)) || ($past(c_n, 3) && !$past(c_n, 4))
            || ($past(c_n, 4) && !$past(c_n, 5));
    endsequence

    a_no_contention: assert property (!(dev_dq_oe && host_dq_oe))
        else $error("Both ends drive the data bus");
    a_deselect_phase: assert property ($rose(port_select_n) |-> k)
        else $error("Select released outside the high link phase");
    a_clock_pair: assert property (k_n == !k)
        else $error("Link clock pair not complementary");
    a_out_clocks: assert property (!$past(rst_in) |-> c == k && c_n == k_n)
        else $error("Output clocks do not follow link clocks");
    a_read_launch: assert property ($rose(dev_dq_oe) |-> s_beat_launch)
        else $error("Read beat not launched by an output clock edge");
    // Read data moves only just after an output clock edge; no edges, no change
    a_dq_edge_only: assert property ($changed(dev_dq) |->
        ($past(c, 3) && !$past(c, 4)) || ($past(c_n, 3) && !$past(c_n, 4)))
        else $error("Read data changed with no output clock edge");
    a_read_span: assert property ($fell(dev_dq_oe) |-> rd_cnt_q == 8'(4 * HALF))
        else $error("Read burst not four beats long");
    a_write_span: assert property ($fell(host_dq_oe) |-> wr_cnt_q == 8'(4 * HALF))
        else $error("Write burst not four beats long");
    a_cmd_setup: assert property ($fell(port_select_n) |->
        !k ##4 s_cmd_held ##[1:30] $rose(port_select_n))
        else $error("Command not held around the link edge");
    a_beat_hold: assert property (($rose(k) || $rose(k_n)) && host_dq_oe |->
        $stable(host_dq) && $stable(lane_wr_n))
        else $error("Write beat or lane mask moved at a link edge");
    a_lanes_idle: assert property (!host_dq_oe |-> &lane_wr_n)
        else $error("Lane enables active outside a write burst");
    a_lock_wait: assert property ($fell(port_select_n) |-> lock_cnt_q >= 16'(LOCK))
        else $error("Command issued before the lock wait");
endmodule

// ===== bench/burst4_ddr_sram_port_tb_top.sv
`timescale 1ns/1ps
module burst4_ddr_sram_port_tb_top;
    import burst4_pkg::*;
    localparam int DW = 36;
    localparam int AW = 8;
    localparam int L = DW / LANE_BITS;
    localparam int BW = BURST_LEN * DW;
    localparam int LOCK = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [AW-1:0] req_addr_in = '0;
    logic [BW-1:0] wr_data_in = '0;
    logic [BURST_LEN*L-1:0] wr_mask_n_in = '1;
    logic req_ready_out, rd_valid_out, single_clk_out, busy_out;
    logic [BW-1:0] rd_data_out;
    logic [DW-1:0] mem [0:2**AW-1];
    logic [BW-1:0] exp_q [$];
    logic [3:0] mask_tab [5] = '{4'h0, 4'hE, 4'hD, 4'h3, 4'hF};
    int num_errors = 0;
    int num_checks = 0;

    always #(CLK_PERIOD_NS / 2.0) clk_in = ~clk_in;

    burst4_link_if #(.DW(DW), .AW(AW)) burst4_link_if_inst ();
    burst4_sram_dev #(.DW(DW), .AW(AW)) burst4_sram_dev_inst (
        .clk_in(clk_in), .rst_in(rst_in), .link(burst4_link_if_inst.dev),
        .single_clk_out(single_clk_out), .busy_out(busy_out));
    burst4_sram_host #(.DW(DW), .AW(AW), .LOCK_KCYCLES(LOCK), .SINGLE_CLK(1'b0))
        burst4_sram_host_inst (
        .clk_in(clk_in), .rst_in(rst_in), .link(burst4_link_if_inst.host),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in),
        .req_addr_in(req_addr_in), .wr_data_in(wr_data_in), .wr_mask_n_in(wr_mask_n_in),
        .req_ready_out(req_ready_out), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out));
    burst4_link_sva #(.DW(DW), .AW(AW), .HALF(K_HALF_CYCLES), .LOCK(LOCK))
        burst4_link_sva_inst (
        .clk_in(clk_in), .rst_in(rst_in), .k(burst4_link_if_inst.k),
        .k_n(burst4_link_if_inst.k_n), .c(burst4_link_if_inst.c),
        .c_n(burst4_link_if_inst.c_n), .dll_on(burst4_link_if_inst.dll_on),
        .port_select_n(burst4_link_if_inst.port_select_n), .rw(burst4_link_if_inst.rw),
        .addr(burst4_link_if_inst.addr), .lane_wr_n(burst4_link_if_inst.lane_wr_n),
        .host_dq(burst4_link_if_inst.host_dq), .host_dq_oe(burst4_link_if_inst.host_dq_oe),
        .dev_dq(burst4_link_if_inst.dev_dq), .dev_dq_oe(burst4_link_if_inst.dev_dq_oe));

    task automatic chk(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [BW-1:0] rnd();
        logic [159:0] t;
        t = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
        return t[BW-1:0];
    endfunction

    // Model update happens at issue; reads queue the merged words
    task automatic access(input logic wr, input logic [AW-1:0] a, input logic [BW-1:0] d,
            input logic [BURST_LEN*L-1:0] m);
        logic [BW-1:0] e;
        logic [AW-1:0] wa;
        int n;
        n = 0;
        e = '0;
        while (req_ready_out !== 1'b1 && n < 2000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            $display("[FAIL] %0t ns: request not accepted", $time);
        end
        for (int b = 0; b < BURST_LEN; b++) begin
            wa = {a[AW-1:2], a[1:0] + 2'(b)};
            for (int i = 0; i < L; i++) begin
                if (wr && !m[b*L+i]) begin
                    mem[wa][i*LANE_BITS+:LANE_BITS] = d[b*DW+i*LANE_BITS+:LANE_BITS];
                end
            end
            e[b*DW+:DW] = mem[wa];
        end
        if (!wr) begin
            exp_q.push_back(e);
        end
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_addr_in = a;
        wr_data_in = d;
        wr_mask_n_in = m;
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask

    always @(negedge clk_in) begin
        if (rd_valid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[FAIL] %0t ns: read data without a request", $time);
            end else begin
                chk(rd_data_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        int seed;
        int n;
        logic [15:0] m;
        seed = $urandom(32'hB462C963);
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        chk(BW'(single_clk_out), BW'(1'b0));
        chk(BW'(burst4_link_if_inst.dev_dq_oe), BW'(1'b0));
        $display("test reset done");
        for (int j = 0; j < 4; j++) begin
            access(1'b1, AW'(16 + 4 * j), rnd(), '0);
            access(1'b0, AW'(16 + 4 * j), '0, '1);
        end
        $display("test whole bursts done");
        // Start addresses off the block boundary wrap inside the block
        access(1'b0, 8'h12, '0, '1);
        access(1'b1, 8'h1B, rnd(), '0);
        access(1'b0, 8'h18, '0, '1);
        access(1'b0, 8'h1D, '0, '1);
        $display("test wrapped bursts done");
        for (int j = 0; j < 5; j++) begin
            m = {mask_tab[(j + 3) % 5], mask_tab[(j + 2) % 5],
                 mask_tab[(j + 1) % 5], mask_tab[j]};
            access(1'b1, 8'h14, rnd(), m);
            access(1'b0, 8'h14, '0, 16'($urandom()));
        end
        $display("test lane masks done");
        repeat (12) begin
            access(1'($urandom_range(1)), AW'(16 + $urandom_range(15)), rnd(), 16'($urandom()));
        end
        $display("test random traffic done");
        n = 0;
        while ((req_ready_out !== 1'b1 || busy_out !== 1'b0) && n < 2000) begin
            @(negedge clk_in);
            n++;
        end
        chk(BW'(n >= 2000), BW'(0));
        @(negedge clk_in);
        chk(BW'(busy_out), BW'(1'b0));
        chk(BW'(exp_q.size()), BW'(0));
        chk(BW'(burst4_link_if_inst.dev_dq_oe), BW'(1'b0));
        $display("test drain done");
        end_sim();
    end

    initial begin
        #(200000);
        num_errors++;
        $display("[FAIL] %0t ns: run did not finish", $time);
        end_sim();
    end
endmodule
